/* src/jfa_pkg.sv */
`default_nettype none
package jfa_pkg;
    // ==========================================================
    // instruction register codes
    localparam logic [15:0] IR_CTRL = 16'h0082;
    localparam logic [15:0] IR_DATA = 16'h0083;
    localparam logic [15:0] IR_ADDR = 16'h0084;
    localparam logic [15:0] IR_SCALE = 16'h0085;
    localparam logic [15:0] IR_BYPASS = 16'hFFFF;
    localparam logic [15:0] IR_CAPT = 16'h0001;
    // ==========================================================
    // indirect command and answer layout
    localparam int CMD_W = 20;
    localparam int RES_W = 18;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h3;
    localparam int PAY_BYTE_LO = 10;
    localparam int PAY_ADDR_LO = 2;
    // ==========================================================
    // control register fields and mode codes
    localparam int WRMD_LO = 4;
    localparam int RDMD_LO = 0;
    localparam logic [3:0] MD_STORE = 4'h0;
    localparam logic [3:0] MD_FLASH = 4'h1;
    localparam logic [3:0] MD_SPECIAL = 4'h2;
    // ==========================================================
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [7:0] SCALE_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    // ==========================================================
    // types
    typedef enum logic [1:0] {
        KIND_READ = 2'h1, KIND_WRITE = 2'h2, KIND_ERASE = 2'h3
    } jfa_flash_kind_t;
    typedef struct packed {
        jfa_flash_kind_t kind;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] prescale;
    } jfa_flash_cmd_t;
    typedef struct packed {
        logic [7:0] rdata;
        logic fail;
    } jfa_flash_rsp_t;
    typedef enum logic [1:0] {ENG_IDLE = 2'h1, ENG_WAIT = 2'h2} jfa_eng_state_t;
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008, ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020,
        ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080, ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } jfa_tap_state_t;

    function automatic logic is_indirect(input logic [15:0] ir);
        return ir == IR_CTRL || ir == IR_DATA || ir == IR_ADDR || ir == IR_SCALE;
    endfunction

    function automatic jfa_tap_state_t tap_next(input jfa_tap_state_t s, input logic tms);
        unique case (s)
            ST_TLR: tap_next = tms ? ST_TLR : ST_RTI;
            ST_RTI: tap_next = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: tap_next = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: tap_next = tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_next = tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: tap_next = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: tap_next = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_RTI;
            default: tap_next = ST_TLR;
        endcase
    endfunction
endpackage
`default_nettype wire

/* src/jfa_flash_engine.sv */
`timescale 1ns/10ps
`default_nettype none
module jfa_flash_engine (
    // system clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // request from test clock side
    input wire logic req_tgl_i,
    input wire jfa_pkg::jfa_flash_cmd_t cmd_i,
    output logic done_tgl_o,
    output jfa_pkg::jfa_flash_rsp_t rsp_o,
    // flash array side
    output logic flash_req_o,
    output jfa_pkg::jfa_flash_cmd_t flash_cmd_o,
    input wire logic flash_ack_i,
    input wire logic [7:0] flash_rdata_i,
    input wire logic flash_fail_i
);
    // ==========================================================
    // request toggle synchroniser
    logic req_s1, req_s2, req_s3;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end else begin
            req_s1 <= req_tgl_i;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end
    // ==========================================================
    // operation sequencer
    jfa_pkg::jfa_eng_state_t state, next_state;
    jfa_pkg::jfa_flash_cmd_t next_cmd;
    jfa_pkg::jfa_flash_rsp_t next_rsp;
    logic next_done;
    always_comb begin
        next_state = state;
        next_cmd = flash_cmd_o;
        next_rsp = rsp_o;
        next_done = done_tgl_o;
        unique case (state)
            jfa_pkg::ENG_IDLE: begin
                if (req_s2 != req_s3) begin
                    next_cmd = cmd_i;
                    next_state = jfa_pkg::ENG_WAIT;
                end
            end
            jfa_pkg::ENG_WAIT: begin
                if (flash_ack_i) begin
                    next_rsp = '{rdata: flash_rdata_i, fail: flash_fail_i};
                    next_done = ~done_tgl_o;
                    next_state = jfa_pkg::ENG_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= jfa_pkg::ENG_IDLE;
            flash_cmd_o <= '0;
            rsp_o <= '0;
            done_tgl_o <= 1'b0;
        end else begin
            state <= next_state;
            flash_cmd_o <= next_cmd;
            rsp_o <= next_rsp;
            done_tgl_o <= next_done;
        end
    end
    assign flash_req_o = state == jfa_pkg::ENG_WAIT;

    a_req_held: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        flash_req_o && !flash_ack_i |=> flash_req_o && $stable(flash_cmd_o))
        else $error("flash request dropped before acknowledge");
endmodule // jfa_flash_engine
`default_nettype wire

/* src/jfa_flash_port.sv */
// Function
// - host selects an indirect register in IR, then shifts opcodes to it
// - incoming command is 20 bits: opcode 19:18, payload 17:0
// - opcode 0x polls, 10 reads, 11 writes
// - poll captures but never updates; one-bit shifts suffice
// - read starts after two opcode bits; host polls busy afterwards
// - write payload up to 18 bits, left-justified at bit 17
// - outgoing word: bit 19 zero, result 18:1, busy at bit 0
// - busy rises at operation start, falls when it completes
// - reads and writes arriving while busy are held, a later one replacing an earlier one
// - command shifted while busy starts when busy is captured low
// - control, scale and address read results right-justified just after busy bit
// - flash address used by all operations, increments after read or write
// - flash address is 16 bits, reset to zero
// - IR codes 0x0082..0x0085 select control, data, address, scale
// - data register: byte at 10:3, fail at 2, busy at 0
`timescale 1ns/10ps
`default_nettype none
module jfa_flash_port (
    // system clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // test access port
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // flash array side
    output logic flash_req_o,
    output jfa_pkg::jfa_flash_cmd_t flash_cmd_o,
    input wire logic flash_ack_i,
    input wire logic [7:0] flash_rdata_i,
    input wire logic flash_fail_i
);
    // ==========================================================
    // tap controller and shift registers
    jfa_pkg::jfa_tap_state_t state, next_state;
    logic [15:0] ir, next_ir, ir_sh, next_ir_sh;
    logic [19:0] dr_sh, next_dr_sh;
    logic next_tdo, next_tdo_oe;
    logic indirect, busy;
    logic [17:0] result, next_result;

    assign indirect = jfa_pkg::is_indirect(ir);

    always_comb begin
        next_state = jfa_pkg::tap_next(state, tms_i);
        next_ir = ir;
        next_ir_sh = ir_sh;
        next_dr_sh = dr_sh;
        unique case (state)
            jfa_pkg::ST_TLR: next_ir = jfa_pkg::IR_BYPASS;
            jfa_pkg::ST_CAP_IR: next_ir_sh = jfa_pkg::IR_CAPT;
            jfa_pkg::ST_SH_IR: next_ir_sh = {tdi_i, ir_sh[15:1]};
            jfa_pkg::ST_UPD_IR: next_ir = ir_sh;
            jfa_pkg::ST_CAP_DR: begin
                // capture always happens, poll included
                next_dr_sh = indirect ? {1'b0, result, busy} : 20'h00000;
            end
            jfa_pkg::ST_SH_DR: begin
                // bits enter at 19 so short commands end up left-justified
                if (indirect) begin
                    next_dr_sh = {tdi_i, dr_sh[19:1]};
                end else begin
                    next_dr_sh = {19'h00000, tdi_i};
                end
            end
            default: ;
        endcase
        next_tdo = (state == jfa_pkg::ST_SH_IR) ? ir_sh[0] : dr_sh[0];
        next_tdo_oe = state == jfa_pkg::ST_SH_IR || state == jfa_pkg::ST_SH_DR;
    end

    always_ff @(posedge tck_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= jfa_pkg::ST_TLR;
            ir <= jfa_pkg::IR_BYPASS;
            ir_sh <= 16'h0000;
            dr_sh <= 20'h00000;
        end else begin
            state <= next_state;
            ir <= next_ir;
            ir_sh <= next_ir_sh;
            dr_sh <= next_dr_sh;
        end
    end

    // tdo changes on the falling edge
    always_ff @(negedge tck_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else begin
            tdo_o <= next_tdo;
            tdo_oe_o <= next_tdo_oe;
        end
    end

    // ==========================================================
    // indirect registers and operation control
    logic [7:0] ctrl, next_ctrl, scale, next_scale, fdata, next_fdata;
    logic [15:0] addr, next_addr;
    logic fail, next_fail, unread, next_unread;
    logic incr, next_incr, is_rd, next_is_rd;
    logic req_tgl, next_req_tgl, done_q, next_done_q;
    logic done_s1, done_s2, done_tgl;
    logic pend_v, next_pend_v;
    logic [19:0] pend, next_pend;
    logic ex_v;
    logic [19:0] ex_w;
    logic [3:0] wrmd, rdmd;
    logic [7:0] pay_byte;
    logic start;
    jfa_pkg::jfa_flash_kind_t kind;
    jfa_pkg::jfa_flash_cmd_t cmd, next_cmd;
    jfa_pkg::jfa_flash_rsp_t rsp;

    assign busy = req_tgl ^ done_q;
    assign wrmd = ctrl[jfa_pkg::WRMD_LO +: 4];
    assign rdmd = ctrl[jfa_pkg::RDMD_LO +: 4];

    always_comb begin
        next_ctrl = ctrl;
        next_scale = scale;
        next_fdata = fdata;
        next_addr = addr;
        next_fail = fail;
        next_unread = unread;
        next_incr = incr;
        next_is_rd = is_rd;
        next_req_tgl = req_tgl;
        next_done_q = done_q;
        next_pend_v = pend_v;
        next_pend = pend;
        next_result = result;
        next_cmd = cmd;
        ex_v = 1'b0;
        ex_w = dr_sh;
        start = 1'b0;
        kind = jfa_pkg::KIND_READ;
        // poll (bit 19 low) never reaches the update step
        if (indirect && state == jfa_pkg::ST_UPD_DR && dr_sh[19]) begin
            if (busy) begin
                next_pend_v = 1'b1;
                next_pend = dr_sh;
            end else begin
                ex_v = 1'b1;
            end
        end
        if (indirect && state == jfa_pkg::ST_CAP_DR && pend_v && !busy) begin
            ex_v = 1'b1;
            ex_w = pend;
            next_pend_v = 1'b0;
        end
        if (state == jfa_pkg::ST_UPD_IR) begin
            next_pend_v = 1'b0;
        end
        // completion, seen only after the done toggle is synchronised
        if (done_q != done_s2) begin
            next_done_q = done_s2;
            next_fail = rsp.fail;
            if (is_rd) begin
                next_fdata = rsp.rdata;
                next_unread = 1'b1;
                next_result = {8'h00, rsp.rdata, rsp.fail, 1'b0};
            end
            if (incr) begin
                next_addr = addr + 16'h0001;
            end
        end
        pay_byte = ex_w[jfa_pkg::PAY_BYTE_LO +: 8];
        if (ex_v && ex_w[19:18] == jfa_pkg::OP_WRITE) begin
            unique case (ir)
                jfa_pkg::IR_CTRL: next_ctrl = pay_byte;
                jfa_pkg::IR_SCALE: next_scale = pay_byte;
                jfa_pkg::IR_ADDR: next_addr = ex_w[jfa_pkg::PAY_ADDR_LO +: 16];
                default: begin
                    next_fdata = pay_byte;
                    if (wrmd == jfa_pkg::MD_FLASH) begin
                        start = 1'b1;
                        kind = jfa_pkg::KIND_WRITE;
                    end else if (wrmd == jfa_pkg::MD_SPECIAL) begin
                        start = 1'b1;
                        kind = jfa_pkg::KIND_ERASE;
                    end
                end
            endcase
        end
        if (ex_v && ex_w[19:18] == jfa_pkg::OP_READ) begin
            unique case (ir)
                jfa_pkg::IR_CTRL: next_result = {10'h000, ctrl};
                jfa_pkg::IR_SCALE: next_result = {10'h000, scale};
                jfa_pkg::IR_ADDR: next_result = {2'h0, addr};
                default: begin
                    if (rdmd == jfa_pkg::MD_FLASH ||
                        (rdmd == jfa_pkg::MD_SPECIAL && !unread)) begin
                        start = 1'b1;
                    end else begin
                        next_result = {8'h00, fdata, fail, 1'b0};
                        next_unread = 1'b0;
                    end
                end
            endcase
        end
        if (start) begin
            next_req_tgl = ~req_tgl;
            next_is_rd = kind == jfa_pkg::KIND_READ;
            next_incr = kind != jfa_pkg::KIND_ERASE;
            next_cmd = '{kind: kind, addr: addr, wdata: next_fdata, prescale: scale};
        end
    end

    always_ff @(posedge tck_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl <= jfa_pkg::CTRL_RST;
            scale <= jfa_pkg::SCALE_RST;
            fdata <= jfa_pkg::DATA_RST;
            addr <= jfa_pkg::ADDR_RST;
            fail <= 1'b0;
            unread <= 1'b0;
            incr <= 1'b0;
            is_rd <= 1'b0;
            req_tgl <= 1'b0;
            done_q <= 1'b0;
            pend_v <= 1'b0;
            pend <= 20'h00000;
            result <= 18'h00000;
            cmd <= '0;
        end else begin
            ctrl <= next_ctrl;
            scale <= next_scale;
            fdata <= next_fdata;
            addr <= next_addr;
            fail <= next_fail;
            unread <= next_unread;
            incr <= next_incr;
            is_rd <= next_is_rd;
            req_tgl <= next_req_tgl;
            done_q <= next_done_q;
            pend_v <= next_pend_v;
            pend <= next_pend;
            result <= next_result;
            cmd <= next_cmd;
        end
    end

    // ==========================================================
    // done toggle back into the test clock domain
    always_ff @(posedge tck_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
        end else begin
            done_s1 <= done_tgl;
            done_s2 <= done_s1;
        end
    end

    jfa_flash_engine u_engine (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .req_tgl_i(req_tgl),
        .cmd_i(cmd),
        .done_tgl_o(done_tgl),
        .rsp_o(rsp),
        .flash_req_o(flash_req_o),
        .flash_cmd_o(flash_cmd_o),
        .flash_ack_i(flash_ack_i),
        .flash_rdata_i(flash_rdata_i),
        .flash_fail_i(flash_fail_i)
    );

    // ==========================================================
    // checks
    a_busy_on_start: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        start |=> busy && req_tgl != $past(req_tgl))
        else $error("busy not raised at operation start");
    a_busy_ignores: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        busy && state == jfa_pkg::ST_UPD_DR |=> $stable(req_tgl) && $stable(ctrl))
        else $error("command acted on while busy");
    a_poll_no_upd: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        state == jfa_pkg::ST_UPD_DR && !dr_sh[19] && done_q == done_s2
        |=> $stable(ctrl) && $stable(addr) && $stable(req_tgl) && $stable(pend_v))
        else $error("poll caused an update");
    a_capture_fmt: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        indirect && state == jfa_pkg::ST_CAP_DR
        |=> !dr_sh[19] && dr_sh[0] == $past(busy) && dr_sh[18:1] == $past(result))
        else $error("captured word has wrong layout");
    a_addr_incr: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        done_q != done_s2 && incr |=> addr == $past(addr) + 16'h0001)
        else $error("address did not increment after operation");
    a_ctrl_write: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        state == jfa_pkg::ST_UPD_DR && ir == jfa_pkg::IR_CTRL && !busy
        && dr_sh[19:18] == jfa_pkg::OP_WRITE |=> ctrl == $past(dr_sh[17:10]))
        else $error("control write payload misplaced");
    a_pend_start: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        indirect && state == jfa_pkg::ST_CAP_DR && pend_v && !busy |=> !pend_v)
        else $error("held command not started when busy seen low");
    a_read_start: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        state == jfa_pkg::ST_UPD_DR && ir == jfa_pkg::IR_DATA && !busy
        && dr_sh[19:18] == jfa_pkg::OP_READ && rdmd == jfa_pkg::MD_FLASH
        |=> busy [*3])
        else $error("flash read not started or ended too soon");
    a_stored_read: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        state == jfa_pkg::ST_UPD_DR && ir == jfa_pkg::IR_DATA && !busy
        && dr_sh[19:18] == jfa_pkg::OP_READ && rdmd == jfa_pkg::MD_STORE
        |=> $stable(req_tgl) && result == {8'h00, $past(fdata), $past(fail), 1'b0})
        else $error("stored read started flash or returned wrong value");
    a_store_only: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        state == jfa_pkg::ST_UPD_DR && ir == jfa_pkg::IR_DATA && !busy
        && dr_sh[19:18] == jfa_pkg::OP_WRITE && wrmd == jfa_pkg::MD_STORE
        |=> $stable(req_tgl) && fdata == $past(dr_sh[17:10]))
        else $error("store-only write started flash or lost data");
    a_erase_addr: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        done_q != done_s2 && !incr |=> $stable(addr))
        else $error("address moved after erase");
    a_addr_write: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        state == jfa_pkg::ST_UPD_DR && ir == jfa_pkg::IR_ADDR && !busy
        && dr_sh[19:18] == jfa_pkg::OP_WRITE |=> addr == $past(dr_sh[17:2]))
        else $error("address write payload misplaced");
    a_held_dropped: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        state == jfa_pkg::ST_UPD_IR |=> !pend_v)
        else $error("held command survived an instruction update");
    a_busy_holds: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        busy && done_q == done_s2 |=> busy)
        else $error("busy fell before the operation completed");
    a_tdo_shift: assert property (@(posedge tck_i) disable iff (!rst_b_i)
        state == jfa_pkg::ST_SH_DR |-> tdo_oe_o && tdo_o == dr_sh[0])
        else $error("test data out not driven from the shift register");

    // ==========================================================
    // scenario covers
    c_read: cover property (@(posedge tck_i) disable iff (!rst_b_i)
        start && kind == jfa_pkg::KIND_READ);
    c_write: cover property (@(posedge tck_i) disable iff (!rst_b_i)
        start && kind == jfa_pkg::KIND_WRITE);
    c_queued: cover property (@(posedge tck_i) disable iff (!rst_b_i)
        pend_v && state == jfa_pkg::ST_CAP_DR && !busy);
    c_erase: cover property (@(posedge tck_i) disable iff (!rst_b_i)
        start && kind == jfa_pkg::KIND_ERASE);
    c_cond_stored: cover property (@(posedge tck_i) disable iff (!rst_b_i)
        ex_v && ir == jfa_pkg::IR_DATA && rdmd == jfa_pkg::MD_SPECIAL && unread);
endmodule // jfa_flash_port
`default_nettype wire

/* bench/jfa_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none
module jfa_flash_model (
    // system clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // flash request and answer
    input wire logic req_i,
    input wire jfa_pkg::jfa_flash_cmd_t cmd_i,
    output logic ack_o,
    output logic [7:0] rdata_o,
    output logic fail_o
);
    // ==========================================================
    // array contents and bookkeeping
    logic [7:0] mem [0:255];
    jfa_pkg::jfa_flash_cmd_t last;
    int ops = 0;
    int delay = 200;

    initial begin
        ack_o = 1'b0;
        rdata_o = 8'h00;
        fail_o = 1'b0;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h3C;
        end
        forever begin
            @(posedge clk_i);
            if (rst_b_i === 1'b1 && req_i === 1'b1) begin
                last = cmd_i;
                repeat (delay) @(posedge clk_i);
                #1;
                // upper half of the space is locked
                fail_o = cmd_i.addr[15];
                rdata_o = mem[cmd_i.addr[7:0]];
                if (cmd_i.kind == jfa_pkg::KIND_WRITE && !fail_o) begin
                    mem[cmd_i.addr[7:0]] = cmd_i.wdata;
                end
                ack_o = 1'b1;
                ops++;
                @(posedge clk_i);
                #1;
                ack_o = 1'b0;
                // stale answer lines scrambled
                rdata_o = ~rdata_o;
                fail_o = ~fail_o;
            end
        end
    end
endmodule // jfa_flash_model
`default_nettype wire

/* bench/jtag_indirect_flash_access_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module jtag_indirect_flash_access_tb;
    // ==========================================================
    // clocks, wiring and counters
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b1;
    logic tck_i = 1'b0;
    logic tms_i = 1'b1;
    logic tdi_i = 1'b0;
    logic tdo_o;
    logic tdo_oe_o;
    logic flash_req_o;
    logic flash_ack_i;
    logic flash_fail_i;
    logic [7:0] flash_rdata_i;
    jfa_pkg::jfa_flash_cmd_t flash_cmd_o;
    logic [19:0] res;
    logic b;
    int n0;
    int mismatches = 0;
    int tests_run = 0;

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    jfa_flash_port i_dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
        .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .flash_req_o(flash_req_o),
        .flash_cmd_o(flash_cmd_o), .flash_ack_i(flash_ack_i),
        .flash_rdata_i(flash_rdata_i), .flash_fail_i(flash_fail_i)
    );

    jfa_flash_model i_flash (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(flash_req_o), .cmd_i(flash_cmd_o),
        .ack_o(flash_ack_i), .rdata_o(flash_rdata_i), .fail_o(flash_fail_i)
    );

    // ==========================================================
    // test port access
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        tms_i = tms;
        tdi_i = tdi;
        #12;
        tdo = tdo_o;
        #12 tck_i = 1'b1;
        #24 tck_i = 1'b0;
    endtask

    // n bits shifted fill the top of the command, first bit out is bit 0
    task automatic scan(input logic ir, input int n, input logic [19:0] v,
                        output logic [19:0] q);
        logic x;
        q = '0;
        tick(1'b1, 1'b0, x);
        if (ir) begin
            tick(1'b1, 1'b0, x);
        end
        tick(1'b0, 1'b0, x);
        tick(1'b0, 1'b0, x);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, v[20 - n + i], q[i]);
        end
        tick(1'b1, 1'b0, x);
        tick(1'b0, 1'b0, x);
    endtask

    task automatic ir_load(input logic [15:0] code);
        logic [19:0] q;
        scan(1'b1, 16, {code, 4'h0}, q);
    endtask

    task automatic wr(input int n, input logic [17:0] pay);
        scan(1'b0, n, {2'b11, pay}, res);
    endtask

    // poll with n-bit shifts until busy reads low
    task automatic idle(input int n);
        int k;
        k = 0;
        scan(1'b0, n, 20'h0, res);
        while (res[0] !== 1'b0 && k < 50) begin
            scan(1'b0, n, 20'h0, res);
            k++;
        end
    endtask

    task automatic rd(input int n);
        scan(1'b0, 2, 20'h80000, res);
        idle(n);
    endtask

    task automatic cmp(input string what, input logic [19:0] exp, input logic [19:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results;
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    initial begin
        #1 rst_b_i = 1'b0;
        repeat (20) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        cmp("oe_idle", 20'h0, {19'h0, tdo_oe_o});
        tick(1'b0, 1'b0, b);
        ir_load(jfa_pkg::IR_ADDR);
        rd(20);
        cmp("addr_rst", 20'h0, res);
        wr(20, {16'h0010, 2'h0});
        rd(20);
        cmp("addr_wr", {3'h0, 16'h0010, 1'b0}, res);
        ir_load(jfa_pkg::IR_CTRL);
        wr(10, {8'h11, 10'h0});
        rd(9);
        cmp("ctrl_short", {11'h0, 8'h11, 1'b0}, res);
        ir_load(jfa_pkg::IR_SCALE);
        wr(10, {8'h5A, 10'h0});
        rd(20);
        cmp("scale", {11'h0, 8'h5A, 1'b0}, res);
        ir_load(jfa_pkg::IR_DATA);
        wr(10, {8'hA5, 10'h0});
        scan(1'b0, 1, 20'h0, res);
        cmp("busy_up", 20'h1, res);
        idle(1);
        cmp("busy_dn", 20'h0, res);
        cmp("mem_wr", 20'hA5, 20'(i_flash.mem[16]));
        cmp("prescale", 20'h5A, 20'(i_flash.last.prescale));
        ir_load(jfa_pkg::IR_ADDR);
        wr(20, {16'h0010, 2'h0});
        ir_load(jfa_pkg::IR_DATA);
        n0 = i_flash.ops;
        scan(1'b0, 2, 20'h80000, res);
        scan(1'b0, 2, 20'h80000, res);
        scan(1'b0, 2, 20'h80000, res);
        idle(20);
        cmp("read_first", {9'h0, 8'hA5, 3'h0}, res);
        idle(20);
        cmp("read_held", {9'h0, 8'h2D, 3'h0}, res);
        cmp("flash_ops", 20'(n0 + 2), 20'(i_flash.ops));
        ir_load(jfa_pkg::IR_ADDR);
        wr(20, {16'h8000, 2'h0});
        ir_load(jfa_pkg::IR_DATA);
        rd(20);
        cmp("read_fail", {9'h0, 8'h3C, 3'h4}, res);
        ir_load(jfa_pkg::IR_ADDR);
        rd(20);
        cmp("addr_inc", {3'h0, 16'h8001, 1'b0}, res);
        ir_load(jfa_pkg::IR_CTRL);
        wr(10, {8'h20, 10'h0});
        ir_load(jfa_pkg::IR_ADDR);
        wr(20, {16'h0030, 2'h0});
        ir_load(jfa_pkg::IR_DATA);
        i_flash.delay = 0;
        wr(10, {8'h77, 10'h0});
        idle(1);
        cmp("erase", 20'h3, 20'(i_flash.last.kind));
        rd(20);
        cmp("stored", {9'h0, 8'h77, 3'h0}, res);
        ir_load(jfa_pkg::IR_ADDR);
        rd(20);
        cmp("addr_erase", {3'h0, 16'h0030, 1'b0}, res);
        ir_load(jfa_pkg::IR_CTRL);
        wr(10, {8'h02, 10'h0});
        ir_load(jfa_pkg::IR_DATA);
        n0 = i_flash.ops;
        wr(10, {8'h44, 10'h0});
        rd(20);
        cmp("cond_flash", {9'h0, 8'h0C, 3'h0}, res);
        rd(20);
        cmp("cond_stored", {9'h0, 8'h0C, 3'h0}, res);
        cmp("cond_ops", 20'(n0 + 1), 20'(i_flash.ops));
        results();
    end

    initial begin
        #400000;
        mismatches++;
        results();
    end
endmodule // jtag_indirect_flash_access_tb
`default_nettype wire
